// ### logic/eight_pin_port.sv
`timescale 1ns/1ps
// What this block does
// (RULE1) Eight pins, each input or output by its own direction bit.
// (RULE2) A 16-bit read/write data register holds the output data.
// (RULE3) Data bits 7 to 0 map to pins 7 to 0 of the same index.
// (RULE4) Bits 15 to 8 are reserved and always read as zero.
// (RULE5) Software writes zero to bits 15 to 8.
// (RULE6) With direction 1, the written data bit drives its pin.
// (RULE7) With direction 1, a read returns the stored bit, not the pin.
// (RULE8) With direction 0, a read returns the pin level.
// (RULE9) With direction 0, a write stores the bit and leaves the pin free.
// (RULE10) Other function: read stored bit, write never reaches the pin.
// (RULE11) Reset clears every data bit.
`include "port_defines.svh"

module eight_pin_port (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst,
  input  wire port_pkg::axil_req_t  i_axi,
  output port_pkg::axil_rsp_t       o_axi,
  input  wire logic [7:0]           i_pin,
  output logic [7:0]                o_pin,
  output logic [7:0]                o_pin_oe
);
  import port_pkg::*;

  port_state_t s_r;
  port_state_t s_nxt;

  // Only byte lane 0 reaches the eight live bits of every register
  function automatic logic [7:0] lane0_merge(input logic [7:0]  old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [7:0] res;
    res = old_v;
    if (strb[0]) begin
      res = new_v[7:0];
    end
    return res;
  endfunction : lane0_merge

  // Low two address bits never select a register
  function automatic logic [11:0] word_addr(input logic [11:0] addr);
    logic [11:0] res;
    res = {addr[11:2], 2'b00};
    return res;
  endfunction : word_addr

  // Decode used by the read response only; the write path decodes in its own case
  function automatic logic is_mapped(input logic [11:0] addr);
    logic hit;
    hit = 1'b0;
    unique case (word_addr(addr))
      `PORT_DATA_OFFSET: begin
        hit = 1'b1;
      end
      `PORT_DIR_OFFSET: begin
        hit = 1'b1;
      end
      `PORT_FUNC_OFFSET: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : is_mapped

  // Unmapped words answer with a slave error
  function automatic logic [1:0] resp_of(input logic [11:0] addr);
    logic [1:0] res;
    if (is_mapped(addr)) begin
      res = 2'b00;
    end else begin
      res = 2'b10;
    end
    return res;
  endfunction : resp_of

  // General output only where direction is 1 and no other function owns it
  function automatic logic [7:0] gp_out_mask(input logic [7:0] dir,
                                             input logic [7:0] func);
    logic [7:0] res;
    res = dir & ~func;
    return res;
  endfunction : gp_out_mask

  // Unmapped words read as zero, and so do the reserved data bits
  function automatic logic [31:0] read_word(input logic [11:0] addr,
                                            input logic [7:0]  data_v,
                                            input logic [7:0]  dir,
                                            input logic [7:0]  func);
    logic [31:0] res;
    res = 32'h0000_0000;
    unique case (word_addr(addr))
      `PORT_DATA_OFFSET: begin
        res = {24'h00_0000, data_v}; // [RULE4]
      end
      `PORT_DIR_OFFSET: begin
        res = {24'h00_0000, dir};
      end
      `PORT_FUNC_OFFSET: begin
        res = {24'h00_0000, func};
      end
      default: begin
        res = 32'h0000_0000;
      end
    endcase
    return res;
  endfunction : read_word

  logic        do_write;
  logic        do_read;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic [7:0]  pin_view;
  logic [7:0]  gp_out;
  logic        aw_open;
  logic        w_open;

  always_comb begin
    // A channel stays shut while the last answer stands: one write at a time
    aw_open  = ~s_r.aw_held & ~s_r.bvalid;
    w_open   = ~s_r.w_held & ~s_r.bvalid;
    wr_addr  = s_r.aw_held ? s_r.aw_addr : i_axi.awaddr;
    wr_data  = s_r.w_held ? s_r.w_data : i_axi.wdata;
    wr_strb  = s_r.w_held ? s_r.w_strb : i_axi.wstrb;
    do_write = (s_r.aw_held | i_axi.awvalid) & (s_r.w_held | i_axi.wvalid)
               & ~s_r.bvalid;
    do_read  = i_axi.arvalid & ~s_r.rvalid;
    // Input pins read the synchronised level; output and other pins the bit
    gp_out   = gp_out_mask(s_r.pin_direction_select, s_r.func_select);
    for (int i = 0; i < 8; i++) begin
      pin_view[i] = (s_r.func_select[i] | gp_out[i]) ? s_r.port_pin_data[i]
                    : s_r.pin_sync2[i]; // [RULE7] [RULE8] [RULE10] [RULE3]
    end
  end

  always_comb begin
    s_nxt = s_r;
    // Pins are asynchronous: two flops before any logic reads them
    s_nxt.pin_sync1 = i_pin;
    s_nxt.pin_sync2 = s_r.pin_sync1;
    if (i_axi.awvalid & aw_open & ~do_write) begin
      s_nxt.aw_held = 1'b1;
      s_nxt.aw_addr = i_axi.awaddr;
    end
    if (i_axi.wvalid & w_open & ~do_write) begin
      s_nxt.w_held = 1'b1;
      s_nxt.w_data = i_axi.wdata;
      s_nxt.w_strb = i_axi.wstrb;
    end
    if (s_r.bvalid & i_axi.bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (do_write) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = 2'b00;
      unique case (word_addr(wr_addr))
        `PORT_DATA_OFFSET: begin
          // Reserved bits are stored as zero whatever software sends
          s_nxt.port_pin_data = {8'h00, lane0_merge(
              s_r.port_pin_data[7:0], wr_data, wr_strb)}; // [RULE2] [RULE4]
        end
        `PORT_DIR_OFFSET: begin
          s_nxt.pin_direction_select = lane0_merge(
              s_r.pin_direction_select, wr_data, wr_strb); // [RULE1]
        end
        `PORT_FUNC_OFFSET: begin
          s_nxt.func_select = lane0_merge(s_r.func_select, wr_data,
              wr_strb);
        end
        default: begin
          s_nxt.bresp = 2'b10;
        end
      endcase
    end
    if (s_r.rvalid & i_axi.rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (do_read) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = resp_of(i_axi.araddr);
      s_nxt.rdata  = read_word(i_axi.araddr,
                               pin_view,
                               s_r.pin_direction_select,
                               s_r.func_select); // [RULE2]
    end
    // Pin driven only as general output; input and other functions float
    for (int i = 0; i < 8; i++) begin
      s_nxt.drive.oe[i] = s_nxt.pin_direction_select[i]
                          & ~s_nxt.func_select[i]; // [RULE6] [RULE9] [RULE10]
      s_nxt.drive.out[i] = s_nxt.drive.oe[i]
                           & s_nxt.port_pin_data[i]; // [RULE6] [RULE3]
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
      s_r.port_pin_data <= `PORT_DATA_RESET; // [RULE11]
      s_r.pin_direction_select <= `PORT_DIR_RESET;
      s_r.func_select <= `PORT_FUNC_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    o_axi.awready = aw_open;
    o_axi.wready  = w_open;
    o_axi.bvalid  = s_r.bvalid;
    o_axi.bresp   = s_r.bresp;
    o_axi.arready = ~s_r.rvalid;
    o_axi.rvalid  = s_r.rvalid;
    o_axi.rdata   = s_r.rdata;
    o_axi.rresp   = s_r.rresp;
    o_pin         = s_r.drive.out;
    o_pin_oe      = s_r.drive.oe;
  end
endmodule : eight_pin_port

// ### logic/port_defines.svh
`ifndef PORT_DEFINES_SVH
`define PORT_DEFINES_SVH

`define PORT_DATA_OFFSET    12'h000
`define PORT_DIR_OFFSET     12'h004
`define PORT_FUNC_OFFSET    12'h008
`define PORT_DATA_RESET     16'h0000
`define PORT_DIR_RESET      8'h00
`define PORT_FUNC_RESET     8'h00
`define PORT_PIN_LSB        0
`define PORT_PIN_MSB        7
`define PORT_RSVD_LSB       8
`define PORT_RSVD_MSB       15

`endif

// ### logic/port_pkg.sv
package port_pkg;
  typedef struct packed {
    logic [11:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        rready;
  } axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

  typedef struct packed {
    logic [15:0] port_pin_data;
    logic [7:0]  pin_direction_select;
    logic [7:0]  func_select;
    logic [7:0]  pin_sync1;
    logic [7:0]  pin_sync2;
    logic        aw_held;
    logic [11:0] aw_addr;
    logic        w_held;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    pin_drive_t  drive;
  } port_state_t;
endpackage : port_pkg

// ### sim/pin_model.sv
`timescale 1ns/1ps
module pin_model (
  input  wire logic [7:0] i_drv,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_ext,
  output logic [7:0]      o_lvl
);
  // Outside source wins only where the port lets go
  assign o_lvl = (i_drv & i_oe) | (i_ext & ~i_oe);
endmodule : pin_model

// ### sim/port_chk_sva.sv
`timescale 1ns/1ps
module port_chk (
  input wire logic                i_clk,
  input wire logic                i_rst,
  input wire port_pkg::axil_req_t i_axi,
  input wire port_pkg::axil_rsp_t o_axi,
  input wire logic [7:0]          i_pin,
  input wire logic [7:0]          o_pin,
  input wire logic [7:0]          o_pin_oe
);
  import port_pkg::*;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  AST_RST: assert property (
    $past(i_rst) |-> (o_pin | o_pin_oe) == 8'h00)
    else $error("pins not clear after reset");
  AST_PIN: assert property (
    $changed(o_pin) |-> $rose(o_axi.bvalid))
    else $error("pin moved without a write");
  AST_OE: assert property (
    $changed(o_pin_oe) |-> $rose(o_axi.bvalid))
    else $error("enable moved without a write");
  AST_UNDRV: assert property (
    (o_pin & ~o_pin_oe) == 8'h00)
    else $error("undriven pin shows a level");
  AST_RSVD: assert property (
    o_axi.rvalid |-> o_axi.rdata[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  AST_RLAT: assert property (
    i_axi.arvalid && o_axi.arready |=> o_axi.rvalid)
    else $error("read answer late");
  AST_RDONE: assert property (
    o_axi.rvalid && i_axi.rready |=> !o_axi.rvalid)
    else $error("read answer held too long");
  AST_WDONE: assert property (
    o_axi.bvalid && i_axi.bready |=> !o_axi.bvalid)
    else $error("write answer held too long");
  AST_WREF: assert property (
    o_axi.bvalid |-> !o_axi.awready && !o_axi.wready)
    else $error("write taken while answer stands");
endmodule : port_chk
bind eight_pin_port port_chk chk_i (.i_clk(i_clk), .i_rst(i_rst),
  .i_axi(i_axi), .o_axi(o_axi), .i_pin(i_pin), .o_pin(o_pin),
  .o_pin_oe(o_pin_oe));

// ### sim/tb.sv
`timescale 1ns/1ps
`include "port_defines.svh"
module tb;
  import port_pkg::*;
  logic i_clk = 1'b0, i_rst = 1'b1;
  axil_req_t req = '0;
  axil_rsp_t rsp;
  logic [7:0] ext = 8'h00, pin, o_pin, oe, d, f, w, e;
  logic [31:0] rd;
  logic [1:0] rr, br;
  logic [3:0] ws = 4'hf;
  integer seed = 32'hd828f3db, err_count = 0, samples_checked = 0;
  always #2 i_clk = ~i_clk;
  eight_pin_port uut (.i_clk(i_clk), .i_rst(i_rst), .i_axi(req),
    .o_axi(rsp), .i_pin(pin), .o_pin(o_pin), .o_pin_oe(oe));
  pin_model dev (.i_drv(o_pin), .i_oe(oe), .i_ext(ext), .o_lvl(pin));
  task automatic chk(string n, logic [31:0] s, logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      err_count++;
      $display("mismatch %s exp %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic wr(logic [11:0] a, logic [31:0] v);
    @(posedge i_clk);
    req.awaddr <= a;
    req.wdata <= v;
    req.wstrb <= ws;
    {req.awvalid, req.wvalid, req.bready} <= 3'b111;
    do begin
      @(posedge i_clk);
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (!rsp.bvalid);
    br = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr
  task automatic rdt(logic [11:0] a);
    @(posedge i_clk);
    req.araddr <= a;
    {req.arvalid, req.rready} <= 2'b11;
    do begin
      @(posedge i_clk);
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (!rsp.rvalid);
    {rd, rr} = {rsp.rdata, rsp.rresp};
    req.rready <= 1'b0;
  endtask : rdt
  function automatic [31:0] exp_rd(logic [7:0] d, f, w, e);
    return {24'h0, (w & (d | f)) | (e & ~d & ~f)};
  endfunction : exp_rd
  task automatic end_sim;
    $display("checked %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_sim
  initial begin
    repeat (8) @(posedge i_clk);
    i_rst <= 0;
    rdt(`PORT_DIR_OFFSET);
    chk("dir0", rd, 32'h0);
    rdt(12'h00c);
    chk("bad", rd | {30'h0, rr}, 32'h2);
    for (int i = 0; i < 24; i++) begin
      {d, f, w, e} = $random(seed);
      // Walking ends of the byte first, then random mixes
      if (i < 2) {d, f, w} = {16'hff00, i ? 8'h80 : 8'h01};
      ext <= e;
      wr(`PORT_DIR_OFFSET, {24'h0, d});
      wr(`PORT_FUNC_OFFSET, {24'h0, f});
      wr(`PORT_DATA_OFFSET, {24'h0, w});
      chk("bresp", {30'h0, br}, 32'h0);
      rdt(`PORT_DATA_OFFSET);
      chk("data", rd, exp_rd(d, f, w, e));
      chk("rresp", {30'h0, rr}, 32'h0);
      chk("oe", {24'h0, oe}, {24'h0, d & ~f});
      chk("pin", {24'h0, o_pin & oe}, {24'h0, w & d & ~f});
      chk("lvl", {24'h0, pin},
          {24'h0, (w & d & ~f) | (e & ~(d & ~f))});
      rdt(`PORT_DIR_OFFSET);
      chk("dir", rd, {24'h0, d});
    end
    // Lane 0 strobe off leaves the byte; an unmapped write is refused
    wr(`PORT_FUNC_OFFSET, 32'h0);
    wr(`PORT_DIR_OFFSET, 32'hff);
    wr(`PORT_DATA_OFFSET, 32'h5a);
    ws = 4'he;
    wr(`PORT_DATA_OFFSET, 32'ha5);
    ws = 4'hf;
    chk("keep", {24'h0, o_pin}, 32'h5a);
    wr(12'h00c, 32'h1);
    chk("bresp_bad", {30'h0, br}, 32'h2);
    // Mid-run reset must clear the stored bits, not only the pins
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    chk("oe_rst", {24'h0, oe}, 32'h0);
    chk("pin_rst", {24'h0, o_pin}, 32'h0);
    wr(`PORT_FUNC_OFFSET, 32'hff);
    rdt(`PORT_DATA_OFFSET);
    chk("data_rst", rd, 32'h0);
    end_sim;
  end
  initial begin
    #40000;
    err_count++;
    end_sim;
  end
endmodule : tb
